// ===== hdl/operating_watchdog_timer.sv
// Operating watchdog timer: prescaler, counter, service location and reset output
`timescale 1ns/1ps
module operating_watchdog_timer #(
    parameter bit          LONG_TIMEOUT    = 1'b1,  // Build option: 2^18-2^4 when set
    parameter bit          STOP_DISABLE    = 1'b0,  // Build option: ignore stop instruction
    parameter int          POWER_UP_CYCLES = watchdog_pkg::POWER_UP_CYCLES,
    parameter logic [7:0]  VECTOR_LOW      = 8'h00  // Arbitrary reset vector low byte
) (
    input  wire logic                        core_clk_in,
    input  wire logic                        reset_in,
    input  wire watchdog_pkg::bus_req_type    bus_in,
    input  wire watchdog_pkg::core_status_type status_in,
    output logic [7:0]                       rdata_out,
    output logic                             rdata_valid_out,
    output logic                             reset_pin_n_out,
    output logic                             chip_reset_out,
    output logic                             watchdog_reset_cause_bit_out,
    output logic                             stop_allowed_out
);
    typedef struct packed {
        logic [11:0] prescale;
        logic [5:0]  counter;
        logic [7:0]  rdata;
        logic        rvalid;
        logic        fire;
        logic        chip_reset;
        logic        cause;
        logic        stop_ok;
    } state_type;
    state_type cur_r, cur_nxt;

    logic power_up_clear;
    logic pin_n;
    logic service;
    logic disabled;
    logic clock_on;
    logic carry;
    logic overflow;

    // Power-up delay clears the prescaler once
    watchdog_power_up #(.CYCLES(POWER_UP_CYCLES)) u_power_up (
        .core_clk_in (core_clk_in),
        .reset_in    (reset_in),
        .clear_out   (power_up_clear)
    );

    // Stretches an overflow into the fixed-length external reset pulse
    watchdog_pulse_gen u_pulse (
        .core_clk_in (core_clk_in),
        .reset_in    (reset_in),
        .fire_in     (cur_r.fire),
        .pin_n_out   (pin_n)
    );

    // Decode of a service write; data value is ignored
    assign service = bus_in.write && (bus_in.addr == watchdog_pkg::SERVICE_ADDR);

    // Test-voltage disables in monitor and break states
    assign disabled = (status_in.monitor_mode
                       && (status_in.reset_pin_high_v || status_in.irq_pin_high_v))
                    || (status_in.break_state && status_in.reset_pin_high_v);

    // Oscillator clock is gated off in stop mode and while test-voltage disabled; wait mode keeps counting
    assign clock_on = !(status_in.in_stop && !STOP_DISABLE) && !disabled;

    localparam logic [11:0] PRESCALE_ONES = 12'hFFF;

    // Short option wraps the prescaler early so the counter carries every 2^7 cycles
    assign carry = LONG_TIMEOUT ? (cur_r.prescale == PRESCALE_ONES)
                                : (cur_r.prescale[6:0] == watchdog_pkg::SHORT_PRESCALE_TOP[6:0]);

    // Overflow lands 2^4 cycles before the counter would wrap, so the period is 2^n-2^4
    assign overflow = clock_on && (cur_r.counter == 6'h3F)
                    && (LONG_TIMEOUT
                        ? (cur_r.prescale == watchdog_pkg::LONG_OVERFLOW_AT)
                        : (cur_r.prescale[6:0] == watchdog_pkg::SHORT_OVERFLOW_AT[6:0]));

    // Prescaler, counter, read port and overflow handling
    always_comb begin
        cur_nxt         = cur_r;
        cur_nxt.fire    = 1'b0;
        cur_nxt.rvalid  = bus_in.read;
        cur_nxt.rdata   = 8'h00;
        cur_nxt.stop_ok = !STOP_DISABLE;
        if (bus_in.read && bus_in.addr == watchdog_pkg::SERVICE_ADDR) begin
            cur_nxt.rdata = VECTOR_LOW;
        end
        if (clock_on) begin
            cur_nxt.prescale = cur_r.prescale + 12'h001;
            if (!LONG_TIMEOUT && carry) begin
                cur_nxt.prescale = watchdog_pkg::PRESCALE_CLEARED;
            end
            if (carry) begin
                cur_nxt.counter = cur_r.counter + 6'h01;
            end
        end
        if (overflow && !service) begin
            cur_nxt.fire       = 1'b1;
            cur_nxt.chip_reset = 1'b1;
            cur_nxt.cause      = 1'b1;
        end
        if (service) begin
            cur_nxt.counter = watchdog_pkg::COUNTER_CLEARED;
            cur_nxt.prescale[11:watchdog_pkg::SERVICE_LOW_BIT] = 8'h00;
        end
        if ((status_in.stop_exec && !STOP_DISABLE) || power_up_clear
            || status_in.vector_fetch) begin
            cur_nxt.prescale = watchdog_pkg::PRESCALE_CLEARED;
        end
        if (status_in.internal_reset) begin
            cur_nxt.prescale   = watchdog_pkg::PRESCALE_CLEARED;
            cur_nxt.counter    = watchdog_pkg::COUNTER_CLEARED;
            cur_nxt.chip_reset = 1'b0;
        end
    end

    // Cause bit survives internal reset so software can read why it restarted
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            cur_r <= '{prescale: 12'h000, counter: 6'h00, rdata: 8'h00, rvalid: 1'b0,
                       fire: 1'b0, chip_reset: 1'b0, cause: 1'b0, stop_ok: 1'b0};
        end else begin
            cur_r <= cur_nxt;
        end
    end

    // Only reset leaves the block; no interrupt or DMA request exists
    assign rdata_out                    = cur_r.rdata;
    assign rdata_valid_out              = cur_r.rvalid;
    assign reset_pin_n_out              = pin_n;
    assign chip_reset_out               = cur_r.chip_reset;
    assign watchdog_reset_cause_bit_out = cur_r.cause;
    assign stop_allowed_out             = cur_r.stop_ok;
endmodule

// ===== hdl/watchdog_pkg.sv
// Constants and types shared by the operating watchdog timer
// Overview of operation
// - Six-bit counter advances on each carry out of the twelve-bit prescaler, or out of its low seven bits with the short option.
// - Unserviced counter overflows and raises reset; build option picks short or long period.
// - Any write to the service location clears counter and prescaler stages 5..12.
// - Overflow drives reset pin low 32 clocks and sets the watchdog cause bit.
// - Reading the service location returns the reset vector low byte.
// - In monitor mode a high test voltage on reset or first irq pin disables it.
// - In break state a high test voltage on the reset pin disables it.
// - Stop instruction clears prescaler and gates the clock off during stop mode.
// - Power-up logic clears the prescaler 4096 clocks after power is applied.
// - Any internal reset clears both prescaler and counter.
// - A reset vector fetch clears the prescaler.
// - No interrupt or DMA requests; the only action is reset.
// - Counting continues in wait mode; routines there must service it.
// - Build option disables the stop instruction so the watchdog cannot be halted.
package watchdog_pkg;
    localparam logic [15:0] SERVICE_ADDR     = 16'hFFFF;
    localparam int          PRESCALE_BITS    = 12;
    localparam int          COUNTER_BITS     = 6;
    localparam int          SERVICE_LOW_BIT  = 4;      // Stage 5 is bit index 4
    localparam logic [11:0] PRESCALE_CLEARED = 12'h000;
    localparam logic [5:0]  COUNTER_CLEARED  = 6'h00;
    localparam logic [11:0] SHORT_PRESCALE_TOP = 12'h07F; // Short option wraps low 7 bits here
    localparam logic [11:0] LONG_OVERFLOW_AT   = 12'hFEF; // 2^4 cycles before a full wrap
    localparam logic [11:0] SHORT_OVERFLOW_AT  = 12'h06F; // 2^4 cycles before a short wrap
    localparam int          RESET_PULSE_CYCLES = 32;
    localparam int          POWER_UP_CYCLES    = 4096;
    localparam logic [12:0] POWER_UP_COUNT     = 13'(POWER_UP_CYCLES);

    typedef struct packed {
        logic        write;
        logic        read;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } bus_req_type;

    typedef struct packed {
        logic stop_exec;
        logic in_stop;
        logic monitor_mode;
        logic break_state;
        logic reset_pin_high_v;
        logic irq_pin_high_v;
        logic vector_fetch;
        logic internal_reset;
    } core_status_type;
endpackage

// ===== hdl/watchdog_power_up.sv
// Power-up delay that fires one prescaler clear after a fixed count
`timescale 1ns/1ps
module watchdog_power_up #(
    parameter int CYCLES = watchdog_pkg::POWER_UP_CYCLES
) (
    input  wire logic core_clk_in,
    input  wire logic reset_in,
    output logic      clear_out
);
    typedef struct packed {
        logic [12:0] count;
        logic        done;
        logic        clear;
    } state_type;
    state_type cur_r, cur_nxt;

    // One pulse when the count reaches its end, then idle until power-up reset again
    always_comb begin
        cur_nxt       = cur_r;
        cur_nxt.clear = 1'b0;
        if (!cur_r.done) begin
            if (cur_r.count == 13'(CYCLES - 1)) begin
                cur_nxt.done  = 1'b1;
                cur_nxt.clear = 1'b1;
            end else begin
                cur_nxt.count = cur_r.count + 13'h0001;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            cur_r <= '{count: 13'h0000, done: 1'b0, clear: 1'b0};
        end else begin
            cur_r <= cur_nxt;
        end
    end
    assign clear_out = cur_r.clear;
endmodule

// ===== hdl/watchdog_pulse_gen.sv
// Fixed-length active-low reset pulse stretcher
`timescale 1ns/1ps
module watchdog_pulse_gen #(
    parameter int LENGTH = watchdog_pkg::RESET_PULSE_CYCLES
) (
    input  wire logic core_clk_in,
    input  wire logic reset_in,
    input  wire logic fire_in,
    output logic      pin_n_out
);
    typedef struct packed {
        logic [5:0] count;
        logic       pin_n;
    } state_type;
    state_type cur_r, cur_nxt;

    // Count down while the pin is held low; a new fire restarts the pulse
    always_comb begin
        cur_nxt = cur_r;
        if (fire_in) begin
            cur_nxt.count = 6'(LENGTH - 1);
            cur_nxt.pin_n = 1'b0;
        end else if (!cur_r.pin_n) begin
            if (cur_r.count == 6'h00) begin
                cur_nxt.pin_n = 1'b1;
            end else begin
                cur_nxt.count = cur_r.count - 6'h01;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            cur_r <= '{count: 6'h00, pin_n: 1'b1};
        end else begin
            cur_r <= cur_nxt;
        end
    end
    assign pin_n_out = cur_r.pin_n;
endmodule

// ===== verification/cpu_bus_model.sv
// Behavioural processor that drives the watchdog system bus
`timescale 1ns/1ps
module cpu_bus_model (
    input  wire logic                 core_clk_in,
    output watchdog_pkg::bus_req_type bus_out
);
    initial bus_out = '0;
    // One strobe cycle then one idle cycle, so calls never collide
    task automatic go(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        bus_out <= '{write: w, read: !w, addr: a, wdata: d};
        @(posedge core_clk_in);
        bus_out <= '0;
    endtask
endmodule

// ===== verification/tb_top.sv
// Self-checking bench for the operating watchdog timer
`timescale 1ns/1ps
module tb_top;
    logic                          core_clk_in;
    logic                          reset_in;
    watchdog_pkg::bus_req_type     bus;
    watchdog_pkg::core_status_type st;
    watchdog_pkg::core_status_type md [4];
    logic [7:0]                    rdata;
    logic                          rv, pin_n, chip, cause, stop_ok, frz;
    logic [15:0]                   a;
    int                            fail_count, checks_done, cyc, age, n;
    assign frz = (st.monitor_mode && (st.reset_pin_high_v || st.irq_pin_high_v))
                 || (st.break_state && st.reset_pin_high_v) || st.in_stop;
    cpu_bus_model cpu_bus_model_inst (.core_clk_in(core_clk_in), .bus_out(bus));
    // Short period and short power-up delay keep the run brief
    operating_watchdog_timer #(.LONG_TIMEOUT(1'b0), .POWER_UP_CYCLES(16), .VECTOR_LOW(8'hA5))
        operating_watchdog_timer_inst (.core_clk_in(core_clk_in), .reset_in(reset_in),
        .bus_in(bus), .status_in(st), .rdata_out(rdata), .rdata_valid_out(rv),
        .reset_pin_n_out(pin_n), .chip_reset_out(chip),
        .watchdog_reset_cause_bit_out(cause), .stop_allowed_out(stop_ok));
    function automatic logic [7:0] exp_rd(input logic [15:0] x);
        return (x === 16'hFFFF) ? 8'hA5 : 8'h00;
    endfunction
    task automatic chk(input logic ok, input string m);
        checks_done++;
        if (!ok) begin
            fail_count++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task automatic print_verdict();
        if (fail_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic tick();
        @(posedge core_clk_in);
        #1;
    endtask
    initial begin
        core_clk_in = 1'b0;
        forever #50 core_clk_in = ~core_clk_in;
    end
    // Reference age of the period and the run ceiling
    always @(posedge core_clk_in) begin
        cyc++;
        if (reset_in || (bus.write && bus.addr == 16'hFFFF) || st.stop_exec || st.vector_fetch)
            age <= 0;
        else if (!frz) age <= age + 1;
        if (cyc == 80000) begin
            chk(1'b0, "timeout");
            print_verdict();
        end
    end
    initial begin
        void'($urandom(32'h0025));
        st = '0;
        reset_in = 1'b1;
        md[0] = '{monitor_mode: 1'b1, reset_pin_high_v: 1'b1, default: 1'b0};
        md[1] = '{monitor_mode: 1'b1, irq_pin_high_v: 1'b1, default: 1'b0};
        md[2] = '{break_state: 1'b1, reset_pin_high_v: 1'b1, default: 1'b0};
        md[3] = '{in_stop: 1'b1, default: 1'b0};
        repeat (10) @(posedge core_clk_in);
        reset_in <= 1'b0;
        tick();
        tick();
        chk(pin_n === 1'b1 && chip === 1'b0 && cause === 1'b0, "reset state");
        chk(stop_ok === 1'b1, "stop allowed");
        cpu_bus_model_inst.go(1'b1, 16'hFFFF, 8'h5A);
        for (n = 0; n < 8; n++) begin
            a = n[0] ? 16'hFFFF : 16'($urandom);
            cpu_bus_model_inst.go(1'b0, a, 8'h00);
            #1;
            chk(rv === 1'b1 && rdata === exp_rd(a), "read data");
        end
        for (n = 0; n < 20; n++) begin
            repeat (300 + $urandom % 300) @(posedge core_clk_in);
            cpu_bus_model_inst.go(1'b1, 16'hFFFF, 8'($urandom));
        end
        chk(chip === 1'b0, "reset while serviced");
        // Each disable condition held well past a full period
        for (n = 0; n < 4; n++) begin
            st <= md[n];
            repeat (9000) @(posedge core_clk_in);
            st <= '0;
            cpu_bus_model_inst.go(1'b1, 16'hFFFF, 8'h3C);
        end
        chk(chip === 1'b0, "reset while disabled");
        // Service, then a full prescaler clear; a write elsewhere mid-period must not service
        cpu_bus_model_inst.go(1'b1, 16'hFFFF, 8'h00);
        st <= '{stop_exec: 1'b1, vector_fetch: 1'b1, default: 1'b0};
        @(posedge core_clk_in);
        st <= '0;
        repeat (4000) tick();
        cpu_bus_model_inst.go(1'b1, 16'hFFFE, 8'hFF);
        for (n = 0; n < 4400 && chip !== 1'b1; n++) tick();
        chk(age == 8176, "period length");
        chk(cause === 1'b1, "cause bit");
        for (n = 0; n < 4 && pin_n !== 1'b0; n++) tick();
        for (n = 0; n < 40 && pin_n === 1'b0; n++) tick();
        chk(n == 32, "pulse length");
        st <= '{internal_reset: 1'b1, default: 1'b0};
        @(posedge core_clk_in);
        st <= '0;
        tick();
        chk(chip === 1'b0 && cause === 1'b1, "internal reset");
        print_verdict();
    end
endmodule

// ===== verification/wdt_chk.sv
// Concurrent checks on the watchdog top-level ports
`timescale 1ns/1ps
module wdt_chk #(
    parameter logic [7:0] VECTOR_LOW = 8'h00
) (
    input wire logic                          core_clk_in,
    input wire logic                          reset_in,
    input wire watchdog_pkg::bus_req_type     bus_in,
    input wire watchdog_pkg::core_status_type status_in,
    input wire logic [7:0]                    rdata_out,
    input wire logic                          rdata_valid_out,
    input wire logic                          reset_pin_n_out,
    input wire logic                          chip_reset_out,
    input wire logic                          watchdog_reset_cause_bit_out
);
    logic [5:0] low_r;
    logic       hit;
    logic       frz;
    assign hit = bus_in.addr == watchdog_pkg::SERVICE_ADDR;
    // Any condition that must hold the count still
    assign frz = (status_in.monitor_mode && (status_in.reset_pin_high_v
                 || status_in.irq_pin_high_v)) || status_in.in_stop
                 || (status_in.break_state && status_in.reset_pin_high_v);
    // Length of the current low pulse on the reset pin
    always_ff @(posedge core_clk_in) begin
        if (reset_in || reset_pin_n_out) begin
            low_r <= 6'h00;
        end else begin
            low_r <= low_r + 6'h01;
        end
    end
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    property p_len; $rose(reset_pin_n_out) |-> low_r == 6'h20; endproperty
    a_len: assert property (p_len) else $error("reset pulse length wrong");
    property p_fire; $rose(chip_reset_out) |=> !reset_pin_n_out; endproperty
    a_fire: assert property (p_fire) else $error("reset pin not driven");
    property p_cause; $rose(chip_reset_out) |-> watchdog_reset_cause_bit_out; endproperty
    a_cause: assert property (p_cause) else $error("cause bit not set");
    property p_keep; watchdog_reset_cause_bit_out |=> watchdog_reset_cause_bit_out; endproperty
    a_keep: assert property (p_keep) else $error("cause bit lost");
    property p_rdv; bus_in.read && hit |=> rdata_valid_out && rdata_out == VECTOR_LOW; endproperty
    a_rdv: assert property (p_rdv) else $error("vector byte not returned");
    property p_rdo; bus_in.read && !hit |=> rdata_valid_out && rdata_out == 8'h00; endproperty
    a_rdo: assert property (p_rdo) else $error("other read not zero");
    property p_svc; bus_in.write && hit |=> !$rose(chip_reset_out); endproperty
    a_svc: assert property (p_svc) else $error("reset despite service");
    property p_frz; $rose(chip_reset_out) |-> !$past(frz); endproperty
    a_frz: assert property (p_frz) else $error("reset while disabled");
    property p_irst; status_in.internal_reset |=> !chip_reset_out; endproperty
    a_irst: assert property (p_irst) else $error("internal reset ignored");
endmodule

bind operating_watchdog_timer wdt_chk #(.VECTOR_LOW(VECTOR_LOW)) wdt_chk_inst (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .bus_in(bus_in), .status_in(status_in),
    .rdata_out(rdata_out), .rdata_valid_out(rdata_valid_out),
    .reset_pin_n_out(reset_pin_n_out), .chip_reset_out(chip_reset_out),
    .watchdog_reset_cause_bit_out(watchdog_reset_cause_bit_out));
